/* dv/initial_reset_control_tb.sv */
// self-checking bench of the initial reset controller against a register model
// assumes reset_source as partner and the oscillator toggled every clock
`timescale 1ns/1ns

module initial_reset_control_tb;
    // one 2 Hz phase at one oscillator rise per two clocks, plus latch stages
    localparam int REL_MAX = 16400;
    localparam int TMO = 90000;

    // ==========================================================
    // stimulus, responses and model
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic oscLevel = 1'b0;
    logic [3:0] regAddr = '0;
    logic [31:0] regWrData = '0;
    logic regWrStb = 1'b0, regRdStb = 1'b0, instrStep = 1'b0, pulseReq = 1'b0;
    logic timerSrc = 1'b0, freqSrc = 1'b0, serOut = 1'b0, slvRdy = 1'b0;
    logic [15:0] ioIn = '0, lowCyc = 16'h0;
    logic [3:0] anIn = '0;
    logic [31:0] regRdData;
    logic coreReset, analogReset, intEnable, intMaskAll, extFlag, serialIn, resetPin_n;
    logic [15:0] progCounter, ioOut, ioOe, ioPu;
    logic [11:0] outPort;
    logic [3:0] anOut, anOe, anSel;
    int badCount = 0, checks = 0, cyc = 0;
    logic [31:0] seed = 32'hC2747DE4;
    logic [31:0] mdl [16] = '{7: 32'hFFF, default: 32'h0};
    logic [15:0] progCount = 16'h0110;
    logic wSet = 1'b0, nSet = 1'b0, eFlag = 1'b0, inRst = 1'b1;
    logic [3:0] spSeq [6] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'h2, 4'h2};
    logic [3:0] regList [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA};

    initial forever #10 core_clk = ~core_clk;

    // fastest legal oscillator keeps the 2 Hz release short in simulation
    always @(posedge core_clk) oscLevel <= ~oscLevel;

    initial_reset_control #(.RELEASE_MAX_CYC(40000)) u_initial_reset_control (
        .core_clk(core_clk), .sys_rst(sys_rst), .resetPin_n(resetPin_n),
        .low_speed_oscillator(oscLevel), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .instrStep(instrStep), .coreReset(coreReset), .analogReset(analogReset),
        .program_counter(progCounter), .intEnable(intEnable), .intMaskAll(intMaskAll),
        .extFlag(extFlag), .timer_output(timerSrc), .frequency_output(freqSrc),
        .serial_output(serOut), .slave_ready_output(slvRdy), .serial_input(serialIn),
        .outPort(outPort), .ioPortIn(ioIn), .ioPortOut(ioOut), .ioPortOe(ioOe),
        .ioPortPullup(ioPu), .analogPortIn(anIn), .analogPortOut(anOut),
        .analogPortOe(anOe), .analogSelect(anSel));

    reset_source u_reset_source (.core_clk(core_clk), .pulseReq(pulseReq),
        .lowCyc(lowCyc), .resetPin_n(resetPin_n));

    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] wmask(input logic [3:0] a);
        case (a)
            4'h1, 4'h2, 4'h3, 4'h6, 4'hA: return 32'hFF;
            4'h5: return 32'h1;
            4'h7: return 32'hFFF;
            4'h8, 4'h9: return 32'hFFFF;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] rdExp(input logic [3:0] a);
        case (a)
            4'h0: return {26'h0, 1'b0, mdl[5][0], eFlag, !(wSet && nSet), 2'b00};
            4'h4: return {16'h0, progCount};
            4'h8: return {16'h0, ioIn};
            4'hA: return {24'h0, mdl[10][7:4], anIn};
            default: return mdl[a];
        endcase
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("Error at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // writes held off while in reset never reach the model
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
        #1;
        if (!inRst)
        begin
            mdl[a] = d & wmask(a);
            if (a == 4'h1) nSet = nSet && !wSet;
            if (a == 4'h2) wSet = wSet && !nSet;
            wSet = wSet || a == 4'h1;
            nSet = nSet || a == 4'h2;
            eFlag = eFlag || a == 4'h3;
        end
    endtask

    task automatic rd(input logic [3:0] a, input string what);
        logic [31:0] exp;
        exp = rdExp(a);
        @(posedge core_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1;
        chk(regRdData, exp, what);
    endtask

    task automatic step(input logic withWr);
        @(posedge core_clk);
        instrStep <= 1'b1;
        regAddr <= 4'h3;
        regWrData <= 32'h5A;
        regWrStb <= withWr;
        @(posedge core_clk);
        instrStep <= 1'b0;
        regWrStb <= 1'b0;
        #1;
        progCount++;
        eFlag = withWr;
        if (withWr) mdl[3] = 32'h5A;
        chk(extFlag, eFlag, "extension flag");
        chk(progCounter, progCount, "counter step");
    endtask

    task automatic pulse(input logic [15:0] n);
        @(posedge core_clk);
        lowCyc <= n;
        pulseReq <= 1'b1;
        @(posedge core_clk);
        pulseReq <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(analogReset, 1, "analog reset");
        chk(coreReset, 0, "core reset early");
        @(posedge core_clk);
        #1;
        chk(coreReset, 1, "core reset");
        inRst = 1'b1;
        mdl[5] = 0;
        mdl[6] = 0;
        mdl[7] = 32'hFFF;
        mdl[9] = 0;
        mdl[10] = mdl[10] & 32'hF;
        {wSet, nSet, eFlag} = 3'b000;
        progCount = 16'h0110;
    endtask

    task automatic waitRelease();
        int n;
        n = 0;
        while (resetPin_n !== 1'b1)
        begin
            @(posedge core_clk);
            #1;
            chk(coreReset, 1, "release with pin low");
        end
        while (coreReset !== 1'b0 && n < REL_MAX)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(coreReset, 0, "release time");
        chk(n >= 2, 1, "release latency");
        chk(progCounter, 16'h0110, "start address");
        chk(analogReset, 0, "analog release");
        inRst = 1'b0;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == TMO)
        begin
            badCount++;
            $display("Error at %0t: run timed out", $time);
            results();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk({ioOe, ioPu, outPort, anOe}, {16'h0, 16'hFFFF, 12'hFFF, 4'h0}, "pins");
        chk({intMaskAll, intEnable, extFlag}, 3'b100, "flags");
        wr(4'h3, 32'h11);
        wr(4'h5, 32'h1);
        rd(4'h3, "write in reset");
        waitRelease();
        rd(4'h0, "status");
        wr(4'hB, rnd());
        rd(4'hB, "unmapped");
        wr(4'h4, rnd());
        rd(4'h4, "counter read only");
        wr(4'h5, 32'h1);
        foreach (spSeq[i])
        begin
            wr(spSeq[i], rnd());
            chk(intMaskAll, !(wSet && nSet), "mask");
            chk(intEnable, wSet && nSet, "enable");
        end
        wr(4'h3, 32'h5A);
        chk(extFlag, 1, "extension set");
        step(1'b0);
        step(1'b1);
        rd(4'h0, "status flags");
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            ioIn <= 16'(rnd());
            anIn <= 4'(rnd());
            foreach (regList[j])
            begin
                wr(regList[j], rnd());
                rd(regList[j], "register image");
            end
            chk({outPort, ioOut, ioOe, ioPu, anOut}, {mdl[7][11:0], mdl[8][15:0],
                mdl[9][15:0], ~mdl[9][15:0], mdl[10][3:0]}, "port pins");
        end
        for (int s = 0; s < 2; s++)
        begin
            if (s == 1) wr(4'h6, 32'h1F);
            for (int v = 0; v < 2; v++)
            begin
                @(posedge core_clk);
                {timerSrc, freqSrc, serOut, slvRdy} <= {4{v[0]}};
                ioIn <= {11'h0, v[0], 4'h0};
                repeat (2) @(posedge core_clk);
                #1;
                chk({outPort[3:2], serialIn, ioOut[7], ioOut[5]}, s ? {5{v[0]}} :
                    {mdl[7][3:2], 1'b0, mdl[8][7], mdl[8][5]}, "alternate pins");
                chk({anSel, anOe}, {s[3:0], mdl[10][7:4] & ~s[3:0]}, "analog sel");
            end
        end
        wr(4'h3, 32'h77);
        wr(4'h9, 32'hFFFF);
        pulse(16'd60);
        // defaults load on the edge after internal reset rises
        @(posedge core_clk);
        #1;
        chk({ioOe, ioPu, outPort, anOe, anSel},
            {16'h0, 16'hFFFF, 12'hFFF, 8'h0}, "pins");
        chk({intMaskAll, extFlag, serialIn}, 3'b100, "reset flags");
        waitRelease();
        rd(4'h1, "pointer kept");
        rd(4'h3, "extension kept");
        rd(4'hA, "analog reset");
        rd(4'h0, "status again");
        results();
    end
endmodule

/* dv/reset_source.sv */
// partner model: board-level reset source (supervisor or push switch)
// assumes the bench clock; the power-up hold is scaled down to keep runs short
`timescale 1ns/1ns

module reset_source
#(
    parameter int SUPPLY_CYC = 20,
    parameter int POWERUP_CYC = 150,
    parameter int PULSE_MIN_CYC = 5000
)
(
    input wire logic core_clk,
    input wire logic pulseReq,
    input wire logic [15:0] lowCyc,
    output logic resetPin_n
);
    int cnt_r = SUPPLY_CYC + POWERUP_CYC;

    // ==========================================================
    // pin driver
    // low from power-on
    always @(posedge core_clk)
    begin
        if (pulseReq)
        begin
            resetPin_n <= 1'b0;
            cnt_r <= (lowCyc < PULSE_MIN_CYC) ? PULSE_MIN_CYC : int'(lowCyc);
        end
        else if (cnt_r > 0)
        begin
            resetPin_n <= 1'b0;
            cnt_r <= cnt_r - 1;
        end
        else
        begin
            resetPin_n <= 1'b1;
        end
    end
endmodule

/* rtl/initial_reset_control.sv */
// initial reset controller: reset latch, cpu reset values, stack pointer
// interrupt mask, extension flag and shared pin defaults
// assumes pins and oscillator level synchronous to core_clk
//
// Function
// - low reset pin starts reset, high releases
// - latch holds pin, drives internal reset
// - only 2 Hz high phase clears latch
// - release within 250 msec of pin high
// - reset loads counter 0110H, clears I, E
// - other cpu registers stay undefined
// - interrupts masked until both pointers written
// - extension register write sets extension flag
// - reset returns pins to plain port defaults
// - alternate pin functions only when selected
// - low pin also resets analog circuits
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "initial_reset_defines.svh"

module initial_reset_control
#(
    parameter int RELEASE_MAX_CYC = `RELEASE_MAX_CYC
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic resetPin_n,
    input wire logic low_speed_oscillator,
    input wire logic [`ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    input wire logic instrStep,
    output logic coreReset,
    output logic analogReset,
    output logic [15:0] program_counter,
    output logic intEnable,
    output logic intMaskAll,
    output logic extFlag,
    input wire logic timer_output,
    input wire logic frequency_output,
    input wire logic serial_output,
    input wire logic slave_ready_output,
    output logic serial_input,
    output logic [11:0] outPort,
    input wire logic [15:0] ioPortIn,
    output logic [15:0] ioPortOut,
    output logic [15:0] ioPortOe,
    output logic [15:0] ioPortPullup,
    input wire logic [3:0] analogPortIn,
    output logic [3:0] analogPortOut,
    output logic [3:0] analogPortOe,
    output logic [3:0] analogSelect
);
    import initial_reset_pkg::*;

    ctrl_state_t st_r;
    ctrl_state_t st_nxt;
    release_if rel ();

    // ==========================================================
    // helpers

    // one decode used by both the write and the read path
    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    // ==========================================================
    // release divider
    assign rel.oscLevel = low_speed_oscillator;

    release_divider divider
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rel(rel)
    );

    // ==========================================================
    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdData = 32'h0000_0000;

        // latch is the internal reset source
        // cleared only by 2 Hz high, pin high
        if (!resetPin_n)
        begin
            st_nxt.resetLatch = 1'b1;
        end
        else if (rel.twoHzHigh)
        begin
            st_nxt.resetLatch = 1'b0;
        end

        // internal reset follows latch one edge later
        st_nxt.coreReset = st_r.resetLatch;
        // analog circuits see the pin directly as well
        st_nxt.analogReset = st_r.resetLatch | ~resetPin_n;

        // normal operation: writes are ignored while reset holds the cpu
        if (!st_r.coreReset)
        begin
            if (instrStep)
            begin
                st_nxt.programCounter = st_r.programCounter + 16'h0001;
                st_nxt.extFlag = 1'b0;
            end
            if (regWrStb)
            begin
                if (hit(regAddr, `ADDR_WIDE_SP))
                begin
                    // re-writing one pointer re-masks until the other
                    st_nxt.wideSp = regWrData[7:0];
                    st_nxt.wideSpSet = 1'b1;
                    if (st_r.wideSpSet && st_r.nibbleSpSet)
                    begin
                        st_nxt.nibbleSpSet = 1'b0;
                    end
                end
                if (hit(regAddr, `ADDR_NIBBLE_SP))
                begin
                    st_nxt.nibbleSp = regWrData[7:0];
                    st_nxt.nibbleSpSet = 1'b1;
                    if (st_r.wideSpSet && st_r.nibbleSpSet)
                    begin
                        st_nxt.wideSpSet = 1'b0;
                    end
                end
                // write sets flag, winning over step clear
                if (hit(regAddr, `ADDR_EXT))
                begin
                    st_nxt.extensionReg = regWrData[7:0];
                    st_nxt.extFlag = 1'b1;
                end
                if (hit(regAddr, `ADDR_FLAGS))
                begin
                    st_nxt.intFlag = regWrData[`FL_INT_FLAG];
                end
                if (hit(regAddr, `ADDR_PIN_SEL))
                begin
                    st_nxt.pinSel = regWrData[7:0];
                end
                if (hit(regAddr, `ADDR_OUT_PORT))
                begin
                    st_nxt.outPort = regWrData[11:0];
                end
                if (hit(regAddr, `ADDR_IO_DATA))
                begin
                    st_nxt.ioData = regWrData[15:0];
                end
                if (hit(regAddr, `ADDR_IO_DIR))
                begin
                    st_nxt.ioDir = regWrData[15:0];
                end
                if (hit(regAddr, `ADDR_AN_PORT))
                begin
                    st_nxt.anData = regWrData[3:0];
                    st_nxt.anDir = regWrData[7:4];
                end
            end
        end

        // read path: data stands in the next cycle only, unmapped reads zero
        if (regRdStb)
        begin
            if (hit(regAddr, `ADDR_STATUS))
            begin
                st_nxt.rdData[`ST_CORE_RESET] = st_r.coreReset;
                st_nxt.rdData[`ST_LATCH] = st_r.resetLatch;
                st_nxt.rdData[`ST_INT_MASKED] = ~(st_r.wideSpSet & st_r.nibbleSpSet);
                st_nxt.rdData[`ST_EXT_FLAG] = st_r.extFlag;
                st_nxt.rdData[`ST_INT_FLAG] = st_r.intFlag;
                st_nxt.rdData[`ST_ANALOG_RESET] = st_r.analogReset;
            end
            if (hit(regAddr, `ADDR_WIDE_SP))
            begin
                st_nxt.rdData[7:0] = st_r.wideSp;
            end
            if (hit(regAddr, `ADDR_NIBBLE_SP))
            begin
                st_nxt.rdData[7:0] = st_r.nibbleSp;
            end
            if (hit(regAddr, `ADDR_EXT))
            begin
                st_nxt.rdData[7:0] = st_r.extensionReg;
            end
            if (hit(regAddr, `ADDR_PC))
            begin
                st_nxt.rdData[15:0] = st_r.programCounter;
            end
            if (hit(regAddr, `ADDR_FLAGS))
            begin
                st_nxt.rdData[`FL_INT_FLAG] = st_r.intFlag;
            end
            if (hit(regAddr, `ADDR_PIN_SEL))
            begin
                st_nxt.rdData[7:0] = st_r.pinSel;
            end
            if (hit(regAddr, `ADDR_OUT_PORT))
            begin
                st_nxt.rdData[11:0] = st_r.outPort;
            end
            if (hit(regAddr, `ADDR_IO_DATA))
            begin
                st_nxt.rdData[15:0] = ioPortIn;
            end
            if (hit(regAddr, `ADDR_IO_DIR))
            begin
                st_nxt.rdData[15:0] = st_r.ioDir;
            end
            if (hit(regAddr, `ADDR_AN_PORT))
            begin
                st_nxt.rdData[7:0] = {st_r.anDir, analogPortIn};
            end
        end

        // fixed cpu values while internal reset holds
        // registers, pointers and data are left untouched
        // pins back to plain ports, outputs high
        if (st_r.coreReset)
        begin
            st_nxt.programCounter = `PC_RESET;
            st_nxt.intFlag = 1'b0;
            st_nxt.extFlag = 1'b0;
            st_nxt.wideSpSet = 1'b0;
            st_nxt.nibbleSpSet = 1'b0;
            st_nxt.pinSel = `PIN_SEL_RESET;
            st_nxt.outPort = `OUT_PORT_RESET;
            st_nxt.ioDir = `IO_DIR_RESET;
            st_nxt.anDir = `AN_DIR_RESET;
        end
    end

    // ==========================================================
    // state register
    // sys_rst acts as power-on: latch set so the cpu waits for release
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.resetLatch <= 1'b1;
            st_r.coreReset <= 1'b1;
            st_r.analogReset <= 1'b1;
            st_r.programCounter <= `PC_RESET;
            st_r.outPort <= `OUT_PORT_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign regRdData = st_r.rdData;
    assign coreReset = st_r.coreReset;
    assign analogReset = st_r.analogReset;
    assign program_counter = st_r.programCounter;
    assign extFlag = st_r.extFlag;
    // everything, the non-maskable one too, masked
    assign intMaskAll = ~(st_r.wideSpSet & st_r.nibbleSpSet);
    assign intEnable = st_r.intFlag & ~intMaskAll;

    // alternate outputs replace port bits only when selected
    always_comb
    begin
        outPort = st_r.outPort;
        if (st_r.pinSel[`PS_TIMER])
        begin
            outPort[`OUT_TIMER] = timer_output;
        end
        if (st_r.pinSel[`PS_FREQ])
        begin
            outPort[`OUT_FREQ] = frequency_output;
        end
    end

    // serial lines take over the second group when enabled
    // inputs keep pull-ups, analog group floats
    always_comb
    begin
        ioPortOut = st_r.ioData;
        ioPortOe = st_r.ioDir;
        if (st_r.pinSel[`PS_SERIAL])
        begin
            ioPortOut[`IO_SERIAL_OUT] = serial_output;
            ioPortOe[`IO_SERIAL_OUT] = 1'b1;
            ioPortOe[`IO_SERIAL_IN] = 1'b0;
            if (st_r.pinSel[`PS_SLAVE])
            begin
                ioPortOut[`IO_SLAVE_READY] = slave_ready_output;
                ioPortOe[`IO_SLAVE_READY] = 1'b1;
            end
        end
        ioPortPullup = ~ioPortOe;
        serial_input = st_r.pinSel[`PS_SERIAL] & ioPortIn[`IO_SERIAL_IN];
    end

    // analog inputs select only on request; no pull-ups on this group
    assign analogSelect = st_r.pinSel[`PS_ANALOG_LSB +: 4];
    assign analogPortOut = st_r.anData;
    assign analogPortOe = st_r.anDir & ~analogSelect;

    // ==========================================================
    // checks

    // cycles since the pin went high with internal reset still set
    logic [31:0] relWait;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !resetPin_n || !st_r.coreReset)
        begin
            relWait <= 32'h0000_0000;
        end
        else
        begin
            relWait <= relWait + 32'h0000_0001;
        end
    end

    pin_low_set_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !resetPin_n |=> st_r.resetLatch ##1 coreReset)
        else $error("low pin did not start reset");
    latch_clear_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $fell(st_r.resetLatch) |-> $past(resetPin_n) && $past(rel.twoHzHigh))
        else $error("latch cleared without pin high and release");
    release_edge_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $fell(coreReset) |-> $past(st_r.resetLatch, 2) && !$past(st_r.resetLatch))
        else $error("internal reset did not follow latch");
    release_time_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        relWait <= 32'(RELEASE_MAX_CYC))
        else $error("release took longer than allowed");
    pc_load_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $fell(coreReset) |-> program_counter == `PC_RESET && !intEnable && !extFlag)
        else $error("cpu reset values wrong at release");
    mask_hold_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        coreReset ##1 !coreReset |-> intMaskAll && !intEnable)
        else $error("interrupts unmasked before pointers written");
    ext_set_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        regWrStb && hit(regAddr, `ADDR_EXT) && !coreReset |=> extFlag)
        else $error("extension write did not set flag");
    pin_default_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        coreReset [*2] |-> outPort == `OUT_PORT_RESET && ioPortOe == 16'h0000
            && ioPortPullup == 16'hFFFF && analogPortOe == 4'h0)
        else $error("pins not at port defaults in reset");
    analog_reset_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !resetPin_n |=> analogReset)
        else $error("analog reset missed a low pin");
    alt_off_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_r.pinSel[`PS_SERIAL] |-> !serial_input && ioPortOe == st_r.ioDir)
        else $error("alternate pin active without selection");
endmodule

/* rtl/initial_reset_defines.svh */
// constants of the initial reset controller: offsets, field positions,
// reset values and timing counts; assumes a 50 MHz core clock
`ifndef INITIAL_RESET_DEFINES_SVH
`define INITIAL_RESET_DEFINES_SVH

// ==========================================================
// register offsets (word index on the plain register port)
`define ADDR_W 4
`define ADDR_STATUS 4'h0
`define ADDR_WIDE_SP 4'h1
`define ADDR_NIBBLE_SP 4'h2
`define ADDR_EXT 4'h3
`define ADDR_PC 4'h4
`define ADDR_FLAGS 4'h5
`define ADDR_PIN_SEL 4'h6
`define ADDR_OUT_PORT 4'h7
`define ADDR_IO_DATA 4'h8
`define ADDR_IO_DIR 4'h9
`define ADDR_AN_PORT 4'hA

// ==========================================================
// field positions
`define ST_CORE_RESET 0
`define ST_LATCH 1
`define ST_INT_MASKED 2
`define ST_EXT_FLAG 3
`define ST_INT_FLAG 4
`define ST_ANALOG_RESET 5
`define FL_INT_FLAG 0
`define PS_TIMER 0
`define PS_FREQ 1
`define PS_SERIAL 2
`define PS_SLAVE 3
`define PS_ANALOG_LSB 4
`define IO_SERIAL_IN 4
`define IO_SERIAL_OUT 5
`define IO_SLAVE_READY 7
`define OUT_TIMER 2
`define OUT_FREQ 3

// ==========================================================
// reset values
`define PC_RESET 16'h0110
`define OUT_PORT_RESET 12'hFFF
`define IO_DIR_RESET 16'h0000
`define AN_DIR_RESET 4'h0
`define PIN_SEL_RESET 8'h00

// ==========================================================
// timing: low-speed oscillator divided down to the release signal
`define CLK_HZ 50000000
`define OSC_HZ 32768
`define RELEASE_HZ 2
`define DIV_PERIOD (`OSC_HZ / `RELEASE_HZ)
`define DIV_W 14
`define RELEASE_MAX_MS 250
`define RELEASE_MAX_CYC ((`RELEASE_MAX_MS * (`CLK_HZ / 1000)))
`define PIN_LOW_MIN_US 100
`define PIN_LOW_MIN_CYC ((`PIN_LOW_MIN_US * (`CLK_HZ / 1000000)))
`define POWERUP_LOW_MIN_US 2000

`endif

/* rtl/initial_reset_pkg.sv */
// types of the initial reset controller
// assumes initial_reset_defines.svh for widths of fields
`include "initial_reset_defines.svh"

package initial_reset_pkg;

    // ==========================================================
    // state of the main controller
    typedef struct packed {
        logic resetLatch;
        logic coreReset;
        logic analogReset;
        logic [15:0] programCounter;
        logic intFlag;
        logic extFlag;
        logic [7:0] extensionReg;
        logic [7:0] wideSp;
        logic [7:0] nibbleSp;
        logic wideSpSet;
        logic nibbleSpSet;
        logic [7:0] pinSel;
        logic [11:0] outPort;
        logic [15:0] ioData;
        logic [15:0] ioDir;
        logic [3:0] anData;
        logic [3:0] anDir;
        logic [31:0] rdData;
    } ctrl_state_t;

    // ==========================================================
    // state of the release divider
    typedef struct packed {
        logic oscPrev;
        logic [`DIV_W-1:0] count;
    } div_state_t;

endpackage

/* rtl/release_divider.sv */
// divides the sampled low-speed oscillator down to the 2 Hz release level
// assumes the oscillator level is synchronous to core_clk
`timescale 1ns/1ns
`include "initial_reset_defines.svh"

module release_divider
(
    input wire logic core_clk,
    input wire logic sys_rst,
    release_if.div rel
);
    import initial_reset_pkg::*;

    div_state_t st_r;
    div_state_t st_nxt;

    // ==========================================================
    // divider
    // count rising oscillator edges; the top bit is the 2 Hz square wave
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.oscPrev = rel.oscLevel;
        if (rel.oscLevel && !st_r.oscPrev)
        begin
            st_nxt.count = st_r.count + `DIV_W'(1);
        end
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // high for the second half of each 2 Hz period, from a flip-flop
    // half period bounds release
    assign rel.twoHzHigh = st_r.count[`DIV_W-1];

    // ==========================================================
    // checks
    div_count_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (rel.oscLevel && !st_r.oscPrev)
            |=> (st_r.count == $past(st_r.count) + `DIV_W'(1)))
        else $error("divider missed an oscillator edge");
endmodule

/* rtl/release_if.sv */
// link between the reset controller and its release divider
// both ends run on the same core clock
`timescale 1ns/1ns

interface release_if;
    logic oscLevel;
    logic twoHzHigh;

    modport ctrl (output oscLevel, input twoHzHigh);
    modport div (input oscLevel, output twoHzHigh);
endinterface
